// ===== include/porvp_consts.svh
`ifndef PORVP_CONSTS_SVH
`define PORVP_CONSTS_SVH

// configuration register indices; byte address is index times four
`define PORVP_IDX_MAP_A 3'h2
`define PORVP_IDX_MAP_B 3'h3
`define PORVP_IDX_CLKEV 3'h4
`define PORVP_IDX_EXTERNAL_BUS_PIN_ROUTE 3'h5
`define PORVP_IDX_EVT 3'h6

// region selectors: vports at 0x040 + n*0x10, real ports at 0x200 + p*0x20
`define PORVP_VP_BASE 6'h01
`define PORVP_PORT_BASE 3'h1

// per-port register indices; virtual port windows reach only DIR to FLAGS, real port windows all eight
`define PORVP_IDX_DIR 3'h0
`define PORVP_IDX_OUT 3'h1
`define PORVP_IDX_IN 3'h2
`define PORVP_IDX_FLAGS 3'h3
`define PORVP_IDX_MASK0 3'h4
`define PORVP_IDX_MASK1 3'h5
`define PORVP_IDX_SENSE_LO 3'h6
`define PORVP_IDX_SENSE_HI 3'h7

// field positions
`define PORVP_CLK_ROUTE_LSB 0
`define PORVP_EVT_ROUTE_LSB 4
`define PORVP_CS_ROUTE_LSB 0
`define PORVP_ADR_ROUTE_LSB 2

`define PORVP_RST_BYTE 8'h00

// real port numbers in port order
`define PORVP_PORT_C 4'h2
`define PORVP_PORT_D 4'h3
`define PORVP_PORT_E 4'h4
`define PORVP_PORT_F 4'h5
`define PORVP_PORT_H 4'h7
`define PORVP_PORT_L 4'hA

`endif

// ===== include/porvp_pkg.sv
package porvp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_DONE = 3'b100
  } porvp_state_e;
  typedef enum logic [2:0] {
    SENSE_BOTH = 3'h0,
    SENSE_RISE = 3'h1,
    SENSE_FALL = 3'h2,
    SENSE_LOW = 3'h3,
    SENSE_OFF = 3'h7
  } porvp_sense_e;
endpackage

// ===== hdl/porvp_sense.sv
`timescale 1ns/10ps
`default_nettype none
module porvp_sense import porvp_pkg::*; #(
  parameter int NPORT = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NPORT*8-1:0] pin_in,
  input wire logic [NPORT*24-1:0] sense_all,
  input wire logic [NPORT*8-1:0] mask0_all,
  input wire logic [NPORT*8-1:0] mask1_all,
  output logic [NPORT*2-1:0] flag_set,
  output logic [NPORT*8-1:0] level_gated
);
  logic [NPORT*8-1:0] prev;
  logic [NPORT*8-1:0] hit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= '0;
    end else begin
      prev <= pin_in;
    end
  end

  genvar g;
  for (g = 0; g < NPORT*8; g++) begin : g_pin
    logic [2:0] cfg;
    assign cfg = sense_all[g*3 +: 3];
    assign hit[g] = (cfg == SENSE_BOTH && (pin_in[g] ^ prev[g])) ||
                    (cfg == SENSE_RISE && pin_in[g] && !prev[g]) ||
                    (cfg == SENSE_FALL && !pin_in[g] && prev[g]) ||
                    (cfg == SENSE_LOW && !pin_in[g]);
    // a disabled input buffer reads low and cannot trigger
    assign level_gated[g] = (cfg != SENSE_OFF) && pin_in[g];
  end
  for (g = 0; g < NPORT; g++) begin : g_port
    assign flag_set[g*2] = |(hit[g*8 +: 8] & mask0_all[g*8 +: 8]);
    assign flag_set[g*2+1] = |(hit[g*8 +: 8] & mask1_all[g*8 +: 8]);
    // checked on every port so a randomly mapped port still reaches it
    chk_rise_sets_flag: assert property (@(posedge clk) disable iff (rst)
      sense_all[g*24 +: 3] == SENSE_RISE && mask0_all[g*8] && $rose(pin_in[g*8])
      |-> flag_set[g*2]) else $error("rising edge did not set flag 0");
  end
endmodule
`default_nettype wire

// ===== hdl/porvp_port_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "porvp_consts.svh"
module porvp_port_bank import porvp_pkg::*; #(
  parameter int NPORT = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [3:0] wr_port,
  input wire logic [2:0] wr_reg,
  input wire logic [11:0] wr_data,
  input wire logic rd_en,
  input wire logic [3:0] rd_port,
  input wire logic [2:0] rd_reg,
  output logic [11:0] rd_data,
  input wire logic [NPORT*2-1:0] flag_set,
  input wire logic [NPORT*8-1:0] level_gated,
  output logic [NPORT*8-1:0] dir_all,
  output logic [NPORT*8-1:0] out_all,
  output logic [NPORT*8-1:0] mask0_all,
  output logic [NPORT*8-1:0] mask1_all,
  output logic [NPORT*24-1:0] sense_all
);
  logic [NPORT*2-1:0] flags_all;

  genvar p;
  for (p = 0; p < NPORT; p++) begin : g_port
    logic hit;
    logic [7:0] dir_q, out_q, m0_q, m1_q;
    logic [23:0] sense_q;
    logic [1:0] flag_q, clr;
    assign hit = wr_en && wr_port == 4'(p);
    assign clr = (hit && wr_reg == `PORVP_IDX_FLAGS) ? wr_data[1:0] : 2'b00;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        dir_q <= `PORVP_RST_BYTE;
        out_q <= `PORVP_RST_BYTE;
        m0_q <= `PORVP_RST_BYTE;
        m1_q <= `PORVP_RST_BYTE;
        sense_q <= '0;
      end else if (hit) begin
        unique case (wr_reg)
          `PORVP_IDX_DIR: dir_q <= wr_data[7:0];
          `PORVP_IDX_OUT: out_q <= wr_data[7:0];
          `PORVP_IDX_MASK0: m0_q <= wr_data[7:0];
          `PORVP_IDX_MASK1: m1_q <= wr_data[7:0];
          `PORVP_IDX_SENSE_LO: sense_q[11:0] <= wr_data;
          `PORVP_IDX_SENSE_HI: sense_q[23:12] <= wr_data;
          default: ; // input levels and flags are not stored here
        endcase
      end
    end
    // a new event wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        flag_q <= 2'b00;
      end else begin
        flag_q <= (flag_q & ~clr) | flag_set[p*2 +: 2];
      end
    end
    assign dir_all[p*8 +: 8] = dir_q;
    assign out_all[p*8 +: 8] = out_q;
    assign mask0_all[p*8 +: 8] = m0_q;
    assign mask1_all[p*8 +: 8] = m1_q;
    assign sense_all[p*24 +: 24] = sense_q;
    assign flags_all[p*2 +: 2] = flag_q;
    chk_flag_set_wins: assert property (@(posedge clk) disable iff (rst)
      flag_set[p*2] |=> flag_q[0]) else $error("flag 0 not set after event");
    chk_flag_clear_one: assert property (@(posedge clk) disable iff (rst)
      hit && wr_reg == `PORVP_IDX_FLAGS && wr_data[0] && !flag_set[p*2] |=> !flag_q[0])
      else $error("write one did not clear flag 0");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      unique case (rd_reg)
        `PORVP_IDX_DIR: rd_data <= {4'h0, dir_all[{rd_port, 3'b000} +: 8]};
        `PORVP_IDX_OUT: rd_data <= {4'h0, out_all[{rd_port, 3'b000} +: 8]};
        `PORVP_IDX_IN: rd_data <= {4'h0, level_gated[{rd_port, 3'b000} +: 8]};
        `PORVP_IDX_FLAGS: rd_data <= {10'h000, flags_all[{rd_port, 1'b0} +: 2]};
        `PORVP_IDX_MASK0: rd_data <= {4'h0, mask0_all[{rd_port, 3'b000} +: 8]};
        `PORVP_IDX_MASK1: rd_data <= {4'h0, mask1_all[{rd_port, 3'b000} +: 8]};
        `PORVP_IDX_SENSE_LO: rd_data <= sense_all[rd_port*24 +: 12];
        `PORVP_IDX_SENSE_HI: rd_data <= sense_all[rd_port*24+12 +: 12];
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  cov_flag_set: cover property (flag_set[1] ##1 flags_all[1]);
endmodule
`default_nettype wire

// ===== hdl/porvp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "porvp_consts.svh"
module porvp_top import porvp_pkg::*; #(
  parameter int NPORT = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPORT*8-1:0] pin_in,
  output logic [NPORT*8-1:0] pin_out,
  output logic [NPORT*8-1:0] pin_oe,
  input wire logic per_clk_level,
  input wire logic [7:0] event_chan,
  input wire logic extbus_enable,
  input wire logic extbus_four_port,
  input wire logic extbus_sdram,
  input wire logic extbus_sram_lite,
  input wire logic [23:0] extbus_addr,
  input wire logic [3:0] extbus_cs
);
  localparam int PIN_C7 = `PORVP_PORT_C*8+7;
  localparam int PIN_D7 = `PORVP_PORT_D*8+7;
  localparam int PIN_F0 = `PORVP_PORT_F*8;
  localparam int PIN_H4 = `PORVP_PORT_H*8+4;

  porvp_state_e state;
  logic [7:0] map_ctrl_a, map_ctrl_b;
  logic [1:0] clock_route_port_sel, event_route_port_sel;
  logic [1:0] extbus_addr_hi_route, extbus_select_route;
  logic [2:0] event_channel_pick;

  logic dec_ok, dec_cfg;
  logic [3:0] dec_port;
  logic [2:0] dec_reg;
  logic [3:0] vp_map;
  logic [7:0] cfg_rd;
  logic rd_en, wr_fire, bank_wr;
  logic [11:0] bank_rd;

  logic [NPORT*8-1:0] dir_all, out_all, mask0_all, mask1_all, level_gated;
  logic [NPORT*24-1:0] sense_all;
  logic [NPORT*2-1:0] flag_set;
  logic [NPORT*8-1:0] next_pin_out;

  logic clk_on, evt_on, cs_on, adr_on, adr_full, evt_bit;
  logic [3:0] clk_port, evt_port, cs_port, adr_port;
  logic [7:0] adr_bits;

  // register map decode; virtual windows are rewritten to the mapped port
  always_comb begin
    unique case (paddr[5:4])
      2'd0: vp_map = map_ctrl_a[3:0];
      2'd1: vp_map = map_ctrl_a[7:4];
      2'd2: vp_map = map_ctrl_b[3:0];
      default: vp_map = map_ctrl_b[7:4];
    endcase
  end

  always_comb begin
    dec_ok = 1'b0;
    dec_cfg = 1'b0;
    dec_port = 4'h0;
    dec_reg = paddr[4:2];
    if (paddr[11:5] == 7'h00) begin
      dec_cfg = 1'b1;
      dec_ok = paddr[4:2] >= `PORVP_IDX_MAP_A && paddr[4:2] <= `PORVP_IDX_EVT;
    end else if (paddr[11:6] == `PORVP_VP_BASE) begin
      dec_port = vp_map;
      dec_reg = {1'b0, paddr[3:2]};
      dec_ok = int'(vp_map) < NPORT;
    end else if (paddr[11:9] == `PORVP_PORT_BASE) begin
      dec_port = paddr[8:5];
      dec_ok = int'(paddr[8:5]) < NPORT;
    end
  end

  always_comb begin
    unique case (paddr[4:2])
      `PORVP_IDX_MAP_A: cfg_rd = map_ctrl_a;
      `PORVP_IDX_MAP_B: cfg_rd = map_ctrl_b;
      `PORVP_IDX_CLKEV: cfg_rd = {2'b00, event_route_port_sel, 2'b00, clock_route_port_sel};
      `PORVP_IDX_EXTERNAL_BUS_PIN_ROUTE: cfg_rd = {4'h0, extbus_addr_hi_route, extbus_select_route};
      `PORVP_IDX_EVT: cfg_rd = {5'h00, event_channel_pick};
      default: cfg_rd = 8'h00;
    endcase
  end

  // the bank read data is registered, so the answer costs one extra access cycle
  assign rd_en = state == ST_IDLE && psel && !penable;
  assign wr_fire = state == ST_DONE && psel && penable && pwrite && dec_ok;
  assign bank_wr = wr_fire && !dec_cfg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (psel && !penable) begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state <= ST_DONE;
          pready <= 1'b1;
          pslverr <= !dec_ok;
          if (!dec_ok) begin
            prdata <= 32'h0000_0000;
          end else if (dec_cfg) begin
            prdata <= {24'h00_0000, cfg_rd};
          end else begin
            prdata <= {20'h0_0000, bank_rd};
          end
        end
        ST_DONE: begin
          if (psel && penable) begin
            state <= ST_IDLE;
            pready <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      map_ctrl_a <= `PORVP_RST_BYTE;
      map_ctrl_b <= `PORVP_RST_BYTE;
    end else if (wr_fire && dec_cfg) begin
      if (paddr[4:2] == `PORVP_IDX_MAP_A) begin
        map_ctrl_a <= pwdata[7:0];
      end
      if (paddr[4:2] == `PORVP_IDX_MAP_B) begin
        map_ctrl_b <= pwdata[7:0];
      end
    end
  end

  // reserved bits are dropped on write so they always read back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_route_port_sel <= 2'b00;
      event_route_port_sel <= 2'b00;
      extbus_addr_hi_route <= 2'b00;
      extbus_select_route <= 2'b00;
      event_channel_pick <= 3'b000;
    end else if (wr_fire && dec_cfg) begin
      if (paddr[4:2] == `PORVP_IDX_CLKEV) begin
        clock_route_port_sel <= pwdata[`PORVP_CLK_ROUTE_LSB +: 2];
        event_route_port_sel <= pwdata[`PORVP_EVT_ROUTE_LSB +: 2];
      end
      if (paddr[4:2] == `PORVP_IDX_EXTERNAL_BUS_PIN_ROUTE) begin
        extbus_addr_hi_route <= pwdata[`PORVP_ADR_ROUTE_LSB +: 2];
        extbus_select_route <= pwdata[`PORVP_CS_ROUTE_LSB +: 2];
      end
      if (paddr[4:2] == `PORVP_IDX_EVT) begin
        event_channel_pick <= pwdata[2:0];
      end
    end
  end

  porvp_port_bank #(.NPORT(NPORT)) u_bank (
    .clk(clk),
    .rst(rst),
    .wr_en(bank_wr),
    .wr_port(dec_port),
    .wr_reg(dec_reg),
    .wr_data(pwdata[11:0]),
    .rd_en(rd_en),
    .rd_port(dec_port),
    .rd_reg(dec_reg),
    .rd_data(bank_rd),
    .flag_set(flag_set),
    .level_gated(level_gated),
    .dir_all(dir_all),
    .out_all(out_all),
    .mask0_all(mask0_all),
    .mask1_all(mask1_all),
    .sense_all(sense_all)
  );

  porvp_sense #(.NPORT(NPORT)) u_sense (
    .clk(clk),
    .rst(rst),
    .pin_in(pin_in),
    .sense_all(sense_all),
    .mask0_all(mask0_all),
    .mask1_all(mask1_all),
    .flag_set(flag_set),
    .level_gated(level_gated)
  );

  function automatic logic [3:0] pin7_port(input logic [1:0] code);
    unique case (code)
      2'b01: return `PORVP_PORT_C;
      2'b10: return `PORVP_PORT_D;
      2'b11: return `PORVP_PORT_E;
      default: return 4'h0;
    endcase
  endfunction

  always_comb begin
    clk_on = clock_route_port_sel != 2'b00;
    clk_port = pin7_port(clock_route_port_sel);
    evt_on = event_route_port_sel != 2'b00;
    evt_port = pin7_port(event_route_port_sel);
    evt_bit = event_chan[event_channel_pick];
    cs_on = extbus_enable;
    unique case (extbus_select_route)
      2'b00: cs_port = `PORVP_PORT_H;
      2'b01: cs_port = `PORVP_PORT_L;
      2'b10: cs_port = `PORVP_PORT_F;
      default: cs_port = `PORVP_PORT_E;
    endcase
    adr_port = extbus_addr_hi_route[0] ? `PORVP_PORT_E : `PORVP_PORT_F;
    adr_full = !extbus_addr_hi_route[1];
    if (adr_full) begin
      if (extbus_sdram) begin
        adr_bits = {4'h0, extbus_addr[11:8]};
      end else if (extbus_sram_lite) begin
        adr_bits = extbus_addr[15:8];
      end else begin
        adr_bits = extbus_addr[23:16];
      end
    end else begin
      adr_bits = {extbus_sdram ? extbus_addr[11:8] : extbus_addr[19:16], 4'h0};
    end
    // the narrow route carries nothing for latch-light sram
    adr_on = extbus_enable && extbus_four_port &&
             !(!adr_full && extbus_sram_lite && !extbus_sdram);
  end

  genvar g;
  for (g = 0; g < NPORT*8; g++) begin : g_pin
    localparam logic [3:0] P = 4'(g/8);
    localparam logic [2:0] B = 3'(g%8);
    always_comb begin
      next_pin_out[g] = out_all[g];
      if (dir_all[g]) begin
        if (clk_on && clk_port == P && B == 3'h7) begin
          next_pin_out[g] = per_clk_level;
        end else if (evt_on && evt_port == P && B == 3'h7) begin
          next_pin_out[g] = evt_bit;
        end else if (cs_on && cs_port == P && B >= 3'h4) begin
          next_pin_out[g] = extbus_cs[B[1:0]];
        end else if (adr_on && adr_port == P && (adr_full || B >= 3'h4)) begin
          next_pin_out[g] = adr_bits[B];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= dir_all;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_clk_on_pin: assert property (clock_route_port_sel == 2'b10 && dir_all[PIN_D7]
    |=> pin_out[PIN_D7] == $past(per_clk_level)) else $error("clock missing on port D pin 7");
  chk_clk_over_evt: assert property (clock_route_port_sel == 2'b01 &&
    event_route_port_sel == 2'b01 && dir_all[PIN_C7] |=> pin_out[PIN_C7] == $past(per_clk_level))
    else $error("event overrode clock on port C pin 7");
  chk_evt_channel: assert property (event_route_port_sel == 2'b10 &&
    clock_route_port_sel != 2'b10 && dir_all[PIN_D7] |=> pin_out[PIN_D7] == $past(evt_bit))
    else $error("picked event channel missing on pin");
  chk_dir_gates: assert property (!dir_all[PIN_C7] |=>
    pin_out[PIN_C7] == $past(out_all[PIN_C7]) && !pin_oe[PIN_C7])
    else $error("input pin carried a routed signal");
  chk_addr_ignored: assert property (!extbus_four_port && dir_all[PIN_F0] |=>
    pin_out[PIN_F0] == $past(out_all[PIN_F0])) else $error("address routed outside four-port");
  chk_addr_route: assert property (extbus_enable && extbus_four_port && !extbus_sdram &&
    !extbus_sram_lite && extbus_addr_hi_route == 2'b00 && dir_all[PIN_F0]
    |=> pin_out[PIN_F0] == $past(extbus_addr[16])) else $error("A16 not on port F pin 0");
  chk_cs_route: assert property (extbus_enable && extbus_select_route == 2'b00 &&
    dir_all[PIN_H4] |=> pin_out[PIN_H4] == $past(extbus_cs[0]))
    else $error("chip select 0 not on port H pin 4");
  chk_apb_timing: assert property (state == ST_IDLE && psel && !penable
    |=> !pready ##1 pready) else $error("apb answer not in second access cycle");
  chk_reserved_zero: assert property (pready && paddr[11:2] == {7'h00, `PORVP_IDX_EXTERNAL_BUS_PIN_ROUTE}
    |-> prdata[31:4] == 28'h000_0000) else $error("reserved route bits read nonzero");
  chk_vport_alias: assert property (wr_fire && paddr == 12'h040 |=>
    dir_all[{$past(map_ctrl_a[3:0]), 3'b000} +: 8] == $past(pwdata[7:0]))
    else $error("virtual direction write missed mapped port");

  cov_clk_out: cover property (clk_on && dir_all[PIN_C7] ##1 pin_out[PIN_C7]);
  cov_vport_wr: cover property (wr_fire && paddr[11:6] == `PORVP_VP_BASE);
  cov_bad_addr: cover property (pready && pslverr);
  cov_cs_out: cover property (cs_on && dir_all[PIN_H4] ##1 pin_out[PIN_H4]);
endmodule
`default_nettype wire

// ===== sim/porvp_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
module porvp_pins_model (
  input wire logic [127:0] pin_out,
  input wire logic [127:0] pin_oe,
  input wire logic [127:0] ext_lvl,
  output logic [127:0] pin_in
);
  // a driven pin reads back its own level, an input pin sees the outside source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "porvp_consts.svh"
module tb import porvp_pkg::*; ();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [127:0] pin_in, pin_out, pin_oe, ext_lvl = '0;
  logic per_clk_level = 1'b0, en = 1'b0, four = 1'b0, sdram = 1'b0, lite = 1'b0;
  logic [7:0] event_chan = 8'h00;
  logic [23:0] addr = 24'h0;
  logic [3:0] cs = 4'h0;
  logic [7:0] dirv [16], outv [16];
  logic [1:0] clkc, evc, csc, adrc;
  logic [2:0] pick;
  logic [31:0] rd, r;
  logic err;
  integer seed = 91104, errors = 0, cmp_count = 0;
  int plist [6] = '{2, 3, 4, 5, 7, 10};
  int p;
  always #2 clk = ~clk;
  porvp_top #(.NPORT(16)) dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .per_clk_level(per_clk_level), .event_chan(event_chan), .extbus_enable(en),
    .extbus_four_port(four), .extbus_sdram(sdram), .extbus_sram_lite(lite),
    .extbus_addr(addr), .extbus_cs(cs));
  porvp_pins_model pm (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .pin_in(pin_in));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("BAD %0t bus transfer never answered", $time);
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic [11:0] pbase(input int q);
    return 12'h200 + 12'(q * 32);
  endfunction
  // overlays are applied lowest priority first so later ones win on a shared pin
  function automatic logic [7:0] exp_byte(input int q);
    logic [7:0] v;
    v = outv[q];
    if (en && four && !(adrc[1] && lite && !sdram) && q == (adrc[0] ? 4 : 5)) begin
      if (!adrc[1]) begin
        v = sdram ? {4'h0, addr[11:8]} : (lite ? addr[15:8] : addr[23:16]);
      end else begin
        v[7:4] = sdram ? addr[11:8] : addr[19:16];
      end
    end
    if (en && q == (csc == 2'h0 ? 7 : csc == 2'h1 ? 10 : csc == 2'h2 ? 5 : 4)) begin
      v[7:4] = cs;
    end
    if (evc != 2'h0 && q == 1 + evc) begin
      v[7] = event_chan[pick];
    end
    if (clkc != 2'h0 && q == 1 + clkc) begin
      v[7] = per_clk_level;
    end
    return (v & dirv[q]) | (outv[q] & ~dirv[q]);
  endfunction
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk({31'h0, pin_out[23]}, 32'h0);
    foreach (plist[k]) rdchk(12'h008 + 12'(4 * k), 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h014, 32'h0F);
    rdchk(12'h014, 32'h0F);
    apb(1'b1, 12'h018, 32'h07);
    rdchk(12'h018, 32'h07);
    // each virtual port aliases a random real port, checked from both windows
    for (int vp = 0; vp < 4; vp++) begin
      p = $random(seed) & 15;
      r = $random(seed);
      apb(1'b1, vp < 2 ? 12'h008 : 12'h00C, 32'(p) << (4 * (vp % 2)));
      apb(1'b1, 12'h040 + 12'(vp * 16), {24'h0, r[7:0]});
      apb(1'b1, 12'h044 + 12'(vp * 16), {24'h0, r[15:8]});
      rdchk(pbase(p), {24'h0, r[7:0]});
      rdchk(pbase(p) + 12'h004, {24'h0, r[15:8]});
      apb(1'b1, pbase(p), {24'h0, r[23:16]});
      rdchk(12'h040 + 12'(vp * 16), {24'h0, r[23:16]});
    end
    // vport 1 on a random port with all pins as inputs
    p = $random(seed) & 15;
    apb(1'b1, 12'h008, 32'(p) << 4);
    apb(1'b1, 12'h050, 32'h0);
    ext_lvl <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    repeat (4) @(posedge clk);
    rdchk(12'h058, {24'h0, ext_lvl[p*8+:8]});
    apb(1'b1, pbase(p) + 12'h018, 32'hFFF);
    repeat (4) @(posedge clk);
    rdchk(12'h058, {24'h0, ext_lvl[p*8+:8] & 8'hF0});
    apb(1'b1, pbase(p) + 12'h018, 32'h001);
    apb(1'b1, pbase(p) + 12'h010, 32'h01);
    ext_lvl[p*8] <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, 12'h05C, 32'h3);
    rdchk(12'h05C, 32'h0);
    ext_lvl[p*8] <= 1'b1;
    repeat (5) @(posedge clk);
    rdchk(12'h05C, 32'h1);
    apb(1'b1, 12'h05C, 32'h0);
    rdchk(pbase(p) + 12'h00C, 32'h1);
    apb(1'b1, 12'h05C, 32'h1);
    rdchk(12'h05C, 32'h0);
    // flag one from a falling edge, then a held low level beats a clear
    apb(1'b1, pbase(p) + 12'h010, 32'h0);
    apb(1'b1, pbase(p) + 12'h014, 32'h1);
    apb(1'b1, pbase(p) + 12'h018, 32'h002);
    ext_lvl[p*8] <= 1'b0;
    repeat (5) @(posedge clk);
    rdchk(12'h05C, 32'h2);
    apb(1'b1, pbase(p) + 12'h018, 32'h003);
    apb(1'b1, 12'h05C, 32'h3);
    rdchk(12'h05C, 32'h2);
    ext_lvl[p*8] <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b1, 12'h05C, 32'h3);
    rdchk(pbase(p) + 12'h00C, 32'h0);
    // sweep every clock, event and select code with random data and modes
    for (int i = 0; i < 64; i++) begin
      clkc = i[1:0];
      evc = i[3:2];
      csc = i[5:4];
      r = $random(seed);
      adrc = r[21:20];
      pick = r[24:22];
      sdram <= r[0];
      lite <= r[1] & ~r[0];
      four <= r[2];
      en <= r[3];
      per_clk_level <= r[4];
      event_chan <= r[15:8];
      cs <= r[19:16];
      addr <= 24'($random(seed));
      foreach (plist[k]) begin
        r = $random(seed);
        dirv[plist[k]] = (i % 8 == 0) ? 8'hFF : r[7:0];
        outv[plist[k]] = r[15:8];
        apb(1'b1, pbase(plist[k]), {24'h0, dirv[plist[k]]});
        apb(1'b1, pbase(plist[k]) + 12'h004, {24'h0, outv[plist[k]]});
      end
      apb(1'b1, 12'h010, {26'h0, evc, 2'h0, clkc});
      apb(1'b1, 12'h014, {28'h0, adrc, csc});
      apb(1'b1, 12'h018, {29'h0, pick});
      repeat (3) @(posedge clk);
      foreach (plist[k]) begin
        chk({24'h0, pin_out[plist[k]*8+:8]}, {24'h0, exp_byte(plist[k])});
        chk({24'h0, pin_oe[plist[k]*8+:8]}, {24'h0, dirv[plist[k]]});
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
